// file: logic/scr_regs.sv
// System control register bank: status word, pull-ups, clock mode, serial clock select.
// Assumes the CPU issues at most one register access per cycle, synchronous to CLK_SYS.
//
// What this block does
// - Status bit seven is the carry flag
// - Skip flags change only by instruction execution
// - Level 00 serves all, 01 high priority
// - Level 10 serves none; 11 undefined
// - Bank flag low: upper half of bank 15, lower half of bank 0
// - Bank flag high: banks 0-4 and 15
// - Working bank zero, or operand bank when enabled
// - Carry kept in power-down reset; others zero
// - Carry reached only by single-bit access
// - Pull-up bits connect port resistors, reset zero
// - High pull-up: bits ports 8, 9; rest zero
// - Clock bit 2 alone stops sub oscillator
// - Clock bit 0 selects sub clock; bit 1 zero
// - Code 000: external clock, gated buffer access
// - Code 001: timer 0 clock, gated buffer access
// - Code 01x: CPU clock, buffer always accessible
// - Code 100 divides by 1024, 111 by 16
`timescale 1ns/1ns
module scr_regs
  import scr_pkg::*;
#(
  parameter int IRQ_N = 8
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // CPU register access
  input wire logic [11:0] ACC_ADDR,
  input wire logic [1:0] ACC_SIZE,
  input wire logic [1:0] ACC_BIT,
  input wire logic ACC_WR,
  input wire logic ACC_RD,
  input wire logic [7:0] ACC_WDATA,
  output logic [7:0] ACC_RDATA,
  output logic ACC_RVALID,
  // Instruction execution results
  input wire logic EXE_CARRY_WE,
  input wire logic EXE_CARRY,
  input wire logic EXE_SKIP_WE,
  input wire logic [2:0] EXE_SKIP,
  input wire logic EXE_SRB_WE,
  input wire logic [1:0] EXE_SRB,
  input wire logic PWR_DOWN,
  // Status word fields
  output logic CARRY,
  output logic [2:0] SKIP_CONDITION_FLAGS,
  output logic [1:0] INTERRUPT_SERVICE_LEVEL,
  output logic MEMORY_BANK_ENABLE,
  output logic WORKING_BANK_ENABLE,
  output logic [1:0] WORKING_BANK,
  // Interrupt gating
  input wire logic [IRQ_N-1:0] IRQ_PEND,
  input wire logic [IRQ_N-1:0] INTERRUPT_PRIORITY_REGISTER,
  output logic [IRQ_N-1:0] IRQ_SERVICE,
  // Data memory window check
  input wire logic [11:0] DM_ADDR,
  output logic DM_ALLOWED,
  // Port pull-ups
  output logic [9:0] PULLUP_EN,
  // Oscillator control
  output logic MAIN_OSC_EN,
  output logic SUB_OSC_EN,
  output logic SUB_CLK_SEL,
  // Serial clocking
  input wire logic SIO_HALTED,
  input wire logic SCK_PIN,
  input wire logic TIMER0_OUTPUT_CLOCK,
  input wire logic CPU_CLK_TICK,
  output logic [2:0] SIO_CLK_SEL,
  output logic SIO_SHIFT_TICK,
  output logic SIO_EXT_CLK,
  output logic SERIAL_SHIFT_BUFFER_ACCESS_EN
);

  // ************************************************************
  // Access decode
  // ************************************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r, input scr_acc_t s);
    // Byte access uses the even nibble of a pair
    hit = (s == SCR_ACC_BYTE) ? (a[11:1] == r[11:1]) : (a == r);
  endfunction

  function automatic logic [3:0] bit_set(input logic [3:0] v, input logic [1:0] b, input logic d);
    logic [3:0] t;
    t = v;
    t[b] = d;
    bit_set = t;
  endfunction

  scr_acc_t size;
  logic psw_lo_hit;
  logic psw_hi_hit;
  logic system_clock_mode_hit;
  logic pu_low_hit;
  logic pu_high_hit;
  logic serial_port_mode_hit;

  always_comb begin
    size = scr_acc_t'(ACC_SIZE);
    psw_lo_hit = hit(ACC_ADDR, SCR_PSW_LO_ADDR, size);
    psw_hi_hit = (size != SCR_ACC_BYTE) && (ACC_ADDR == SCR_PSW_HI_ADDR);
    system_clock_mode_hit = (size == SCR_ACC_BIT) && (ACC_ADDR == SCR_SYSTEM_CLOCK_MODE_ADDR);
    pu_low_hit = (size == SCR_ACC_BYTE) && hit(ACC_ADDR, SCR_PU_LOW_ADDR, size);
    pu_high_hit = (size == SCR_ACC_NIB) && (ACC_ADDR == SCR_PU_HIGH_ADDR);
    serial_port_mode_hit = (size == SCR_ACC_BYTE) && hit(ACC_ADDR, SCR_SERIAL_PORT_MODE_ADDR, size);
  end

  // ************************************************************
  // Status word
  // ************************************************************
  logic [3:0] psw_lo_r;
  logic [3:0] psw_lo_nxt;
  logic [2:0] skip_r;
  logic [2:0] skip_nxt;
  logic [1:0] bank_r;
  logic [1:0] bank_nxt;
  logic carry_r;
  logic carry_nxt;

  always_comb begin
    psw_lo_nxt = psw_lo_r;
    if (ACC_WR && psw_lo_hit) begin
      if (size == SCR_ACC_BIT) begin
        psw_lo_nxt = bit_set(psw_lo_r, ACC_BIT, ACC_WDATA[0]);
      end else begin
        psw_lo_nxt = ACC_WDATA[3:0];
      end
    end
    // Skip flags ignore every register write
    skip_nxt = EXE_SKIP_WE ? EXE_SKIP : skip_r;
    bank_nxt = EXE_SRB_WE ? EXE_SRB : bank_r;
    carry_nxt = carry_r;
    if (ACC_WR && psw_hi_hit && size == SCR_ACC_BIT && ACC_BIT == 2'(SCR_PSW_CARRY_BIT)) begin
      carry_nxt = ACC_WDATA[0];
    end
    // Execution result wins over a same-cycle bit write
    if (EXE_CARRY_WE) begin
      carry_nxt = EXE_CARRY;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      psw_lo_r <= SCR_PSW_LO_RST;
      skip_r <= SCR_SKIP_RST;
      bank_r <= 2'h0;
    end else begin
      psw_lo_r <= psw_lo_nxt;
      skip_r <= skip_nxt;
      bank_r <= bank_nxt;
    end
  end

  // Carry has a synchronous reset that is skipped while PWR_DOWN is high, so a power-down reset cannot disturb it
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      if (!PWR_DOWN) begin
        carry_r <= 1'b0;
      end
    end else begin
      carry_r <= carry_nxt;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  logic [3:0] system_clock_mode_r;
  logic [3:0] system_clock_mode_nxt;
  logic [7:0] pu_low_r;
  logic [7:0] pu_low_nxt;
  logic [SCR_PU_HIGH_W-1:0] pu_high_r;
  logic [SCR_PU_HIGH_W-1:0] pu_high_nxt;
  logic [2:0] siosel_r;
  logic [2:0] siosel_nxt;

  always_comb begin
    system_clock_mode_nxt = system_clock_mode_r;
    pu_low_nxt = pu_low_r;
    pu_high_nxt = pu_high_r;
    siosel_nxt = siosel_r;
    if (ACC_WR && system_clock_mode_hit) begin
      system_clock_mode_nxt = bit_set(system_clock_mode_r, ACC_BIT, ACC_WDATA[0]);
    end
    system_clock_mode_nxt[1] = 1'b0;
    if (ACC_WR && pu_low_hit) begin
      pu_low_nxt = ACC_WDATA;
    end
    // Upper two bits are not stored at all
    if (ACC_WR && pu_high_hit) begin
      pu_high_nxt = ACC_WDATA[SCR_PU_HIGH_W-1:0];
    end
    // Shifter start, enable and mode bits live elsewhere
    if (ACC_WR && serial_port_mode_hit) begin
      siosel_nxt = ACC_WDATA[SCR_SERIAL_PORT_MODE_SEL_LSB +: 3];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      system_clock_mode_r <= SCR_SYSTEM_CLOCK_MODE_RST;
      pu_low_r <= SCR_PU_LOW_RST;
      pu_high_r <= SCR_PU_HIGH_RST;
      siosel_r <= SCR_SIOSEL_RST;
    end else begin
      system_clock_mode_r <= system_clock_mode_nxt;
      pu_low_r <= pu_low_nxt;
      pu_high_r <= pu_high_nxt;
      siosel_r <= siosel_nxt;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic rvalid_r;

  always_comb begin
    rdata_nxt = 8'h00;
    // Write-only registers read as zero
    if (ACC_RD && psw_lo_hit) begin
      unique case (size)
        SCR_ACC_BIT: rdata_nxt = {7'h00, psw_lo_r[ACC_BIT]};
        SCR_ACC_NIB: rdata_nxt = {4'h0, psw_lo_r};
        default: rdata_nxt = {1'b0, skip_r, psw_lo_r};
      endcase
    end else if (ACC_RD && psw_hi_hit) begin
      if (size == SCR_ACC_BIT) begin
        rdata_nxt = {7'h00, (ACC_BIT == 2'(SCR_PSW_CARRY_BIT)) ? carry_r : skip_r[ACC_BIT]};
      end else begin
        rdata_nxt = {5'h00, skip_r};
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= ACC_RD;
    end
  end

  // ************************************************************
  // Decoded behaviour
  // ************************************************************
  scr_isl_t isl;
  logic [3:0] dm_bank;

  always_comb begin
    isl = scr_isl_t'(psw_lo_r[SCR_PSW_IS_LSB +: 2]);
    unique case (isl)
      SCR_IS_ALL: IRQ_SERVICE = IRQ_PEND;
      SCR_IS_HIGH: IRQ_SERVICE = IRQ_PEND & INTERRUPT_PRIORITY_REGISTER;
      // Undefined level treated as blocking, the safe choice
      SCR_IS_NONE, SCR_IS_UNDEF: IRQ_SERVICE = '0;
    endcase
    dm_bank = DM_ADDR[11:8];
    if (psw_lo_r[SCR_PSW_EMB_BIT]) begin
      DM_ALLOWED = (dm_bank <= SCR_DM_TOP_BANK) || (dm_bank == SCR_DM_SFR_BANK);
    end else begin
      DM_ALLOWED = (DM_ADDR >= SCR_DM_B15_LO) || (DM_ADDR <= SCR_DM_B0_HI);
    end
    WORKING_BANK = psw_lo_r[SCR_PSW_ERB_BIT] ? bank_r : 2'h0;
  end

  // ************************************************************
  // Serial clock selector
  // ************************************************************
  scr_sio_if sio ();

  assign sio.clk_sel = siosel_r;
  assign sio.halted = SIO_HALTED;
  assign sio.sck_pin = SCK_PIN;
  assign sio.t0_clk = TIMER0_OUTPUT_CLOCK;
  assign sio.cpu_tick = CPU_CLK_TICK;

  scr_sioclk #(
    .DIV_W(SCR_SIO_SLOW_EXP)
  ) u_sioclk (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .sio(sio.sel)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign ACC_RDATA = rdata_r;
  assign ACC_RVALID = rvalid_r;
  assign CARRY = carry_r;
  assign SKIP_CONDITION_FLAGS = skip_r;
  assign INTERRUPT_SERVICE_LEVEL = psw_lo_r[SCR_PSW_IS_LSB +: 2];
  assign MEMORY_BANK_ENABLE = psw_lo_r[SCR_PSW_EMB_BIT];
  assign WORKING_BANK_ENABLE = psw_lo_r[SCR_PSW_ERB_BIT];
  assign PULLUP_EN = {pu_high_r, pu_low_r};
  assign MAIN_OSC_EN = ~system_clock_mode_r[SCR_SYSTEM_CLOCK_MODE_MAIN_BIT];
  // Power-down does not touch this enable
  assign SUB_OSC_EN = ~system_clock_mode_r[SCR_SYSTEM_CLOCK_MODE_SUB_BIT];
  assign SUB_CLK_SEL = system_clock_mode_r[SCR_SYSTEM_CLOCK_MODE_SEL_BIT];
  assign SIO_CLK_SEL = siosel_r;
  assign SIO_SHIFT_TICK = sio.shift_tick;
  assign SIO_EXT_CLK = sio.ext_clk;
  assign SERIAL_SHIFT_BUFFER_ACCESS_EN = sio.buf_en;

endmodule // scr_regs

// file: logic/scr_pkg.sv
// Constants shared by the system control register bank.
// Assumes nibble-addressed data memory with a 12-bit address.
package scr_pkg;

  // ************************************************************
  // Register addresses (nibble addresses)
  // ************************************************************
  localparam logic [11:0] SCR_PSW_LO_ADDR = 12'h0fb0;
  localparam logic [11:0] SCR_PSW_HI_ADDR = 12'h0fb1;
  localparam logic [11:0] SCR_SYSTEM_CLOCK_MODE_ADDR = 12'h0fb7;
  localparam logic [11:0] SCR_PU_LOW_ADDR = 12'h0fdc;
  localparam logic [11:0] SCR_PU_HIGH_ADDR = 12'h0fde;
  localparam logic [11:0] SCR_SERIAL_PORT_MODE_ADDR = 12'h0fe0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] SCR_PSW_LO_RST = 4'h0;
  localparam logic [2:0] SCR_SKIP_RST = 3'h0;
  localparam logic [3:0] SCR_SYSTEM_CLOCK_MODE_RST = 4'h0;
  localparam logic [7:0] SCR_PU_LOW_RST = 8'h00;
  localparam logic [1:0] SCR_PU_HIGH_RST = 2'h0;
  localparam logic [2:0] SCR_SIOSEL_RST = 3'h0;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SCR_PSW_ERB_BIT = 0;
  localparam int SCR_PSW_EMB_BIT = 1;
  localparam int SCR_PSW_IS_LSB = 2;
  localparam int SCR_PSW_CARRY_BIT = 3;
  localparam int SCR_SYSTEM_CLOCK_MODE_SEL_BIT = 0;
  localparam int SCR_SYSTEM_CLOCK_MODE_SUB_BIT = 2;
  localparam int SCR_SYSTEM_CLOCK_MODE_MAIN_BIT = 3;
  localparam int SCR_SERIAL_PORT_MODE_SEL_LSB = 5;
  localparam int SCR_PU_HIGH_W = 2;

  // ************************************************************
  // Data memory windows
  // ************************************************************
  localparam logic [11:0] SCR_DM_B15_LO = 12'h0f80;
  localparam logic [11:0] SCR_DM_B0_HI = 12'h007f;
  localparam logic [3:0] SCR_DM_TOP_BANK = 4'h4;
  localparam logic [3:0] SCR_DM_SFR_BANK = 4'hf;

  // ************************************************************
  // Serial prescaler
  // ************************************************************
  localparam int SCR_SIO_SLOW_EXP = 10;
  localparam int SCR_SIO_FAST_EXP = 4;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    SCR_ACC_BIT = 2'h0,
    SCR_ACC_NIB = 2'h1,
    SCR_ACC_BYTE = 2'h2
  } scr_acc_t;

  typedef enum logic [1:0] {
    SCR_IS_ALL = 2'h0,
    SCR_IS_HIGH = 2'h1,
    SCR_IS_NONE = 2'h2,
    SCR_IS_UNDEF = 2'h3
  } scr_isl_t;

  typedef enum logic [2:0] {
    SCR_SIO_EXT = 3'h0,
    SCR_SIO_T0 = 3'h1,
    SCR_SIO_CPU0 = 3'h2,
    SCR_SIO_CPU1 = 3'h3,
    SCR_SIO_DIV10 = 3'h4,
    SCR_SIO_RSV5 = 3'h5,
    SCR_SIO_RSV6 = 3'h6,
    SCR_SIO_DIV4 = 3'h7
  } scr_siosel_t;

endpackage

// file: logic/scr_sio_if.sv
// Carrier between the register bank and the serial clock selector.
// Assumes both ends share CLK_SYS.
`timescale 1ns/1ns
interface scr_sio_if;
  logic [2:0] clk_sel;
  logic halted;
  logic sck_pin;
  logic t0_clk;
  logic cpu_tick;
  logic shift_tick;
  logic ext_clk;
  logic buf_en;

  modport regs (output clk_sel, output halted, output sck_pin, output t0_clk, output cpu_tick,
    input shift_tick, input ext_clk, input buf_en);
  modport sel (input clk_sel, input halted, input sck_pin, input t0_clk, input cpu_tick,
    output shift_tick, output ext_clk, output buf_en);
endinterface // scr_sio_if

// file: logic/scr_sioclk.sv
// Serial shifter clock source selector and prescaler.
// Assumes all inputs are synchronous to the system clock.
`timescale 1ns/1ns
module scr_sioclk
  import scr_pkg::*;
#(
  parameter int DIV_W = SCR_SIO_SLOW_EXP
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register side
  scr_sio_if.sel sio
);

  // ************************************************************
  // Free-running prescaler
  // ************************************************************
  logic [DIV_W-1:0] pre_r;
  logic [DIV_W-1:0] pre_nxt;
  logic tick_nxt;
  logic tick_r;

  always_comb begin
    pre_nxt = pre_r + DIV_W'(1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // ************************************************************
  // Source select
  // ************************************************************
  always_comb begin
    sio.ext_clk = 1'b0;
    sio.buf_en = 1'b0;
    tick_nxt = 1'b0;
    unique case (scr_siosel_t'(sio.clk_sel))
      SCR_SIO_EXT: begin
        sio.ext_clk = 1'b1;
        sio.buf_en = sio.halted | sio.sck_pin;
      end
      SCR_SIO_T0: begin
        tick_nxt = sio.t0_clk;
        sio.buf_en = sio.halted | sio.sck_pin;
      end
      SCR_SIO_CPU0, SCR_SIO_CPU1: begin
        tick_nxt = sio.cpu_tick;
        sio.buf_en = 1'b1;
      end
      // One tick every 2^n system clocks
      SCR_SIO_DIV10: begin
        tick_nxt = (pre_r == '1);
        sio.buf_en = 1'b1;
      end
      SCR_SIO_DIV4: begin
        tick_nxt = (pre_r[SCR_SIO_FAST_EXP-1:0] == '1);
        sio.buf_en = 1'b1;
      end
      // Reserved codes give no shift clock
      SCR_SIO_RSV5, SCR_SIO_RSV6: begin
        sio.buf_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  assign sio.shift_tick = tick_r;

endmodule // scr_sioclk

// file: sim/scr_regs_sva.sv
// Concurrent checks on the system control register bank ports.
// Assumes it is bound to scr_regs and sees only that module's ports.
`timescale 1ns/1ns
module scr_regs_sva
  import scr_pkg::*;
#(
  parameter int IRQ_N = 8
) (
  // Clock, reset and access
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [11:0] ACC_ADDR,
  input wire logic [1:0] ACC_SIZE,
  input wire logic [1:0] ACC_BIT,
  input wire logic ACC_WR,
  input wire logic [7:0] ACC_WDATA,
  // Execution and status word
  input wire logic EXE_CARRY_WE,
  input wire logic EXE_SKIP_WE,
  input wire logic [2:0] EXE_SKIP,
  input wire logic PWR_DOWN,
  input wire logic CARRY,
  input wire logic [2:0] SKIP_CONDITION_FLAGS,
  input wire logic [1:0] INTERRUPT_SERVICE_LEVEL,
  input wire logic MEMORY_BANK_ENABLE,
  input wire logic WORKING_BANK_ENABLE,
  input wire logic [1:0] WORKING_BANK,
  input wire logic [IRQ_N-1:0] IRQ_PEND,
  input wire logic [IRQ_N-1:0] INTERRUPT_PRIORITY_REGISTER,
  input wire logic [IRQ_N-1:0] IRQ_SERVICE,
  input wire logic [11:0] DM_ADDR,
  input wire logic DM_ALLOWED,
  // Control outputs
  input wire logic [9:0] PULLUP_EN,
  input wire logic MAIN_OSC_EN,
  input wire logic SUB_OSC_EN,
  input wire logic SIO_HALTED,
  input wire logic SCK_PIN,
  input wire logic [2:0] SIO_CLK_SEL,
  input wire logic SERIAL_SHIFT_BUFFER_ACCESS_EN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  logic carry_wr;
  logic sub_wr;
  assign carry_wr = ACC_WR && ACC_SIZE == 2'h0 && ACC_ADDR == SCR_PSW_HI_ADDR && ACC_BIT == 2'h3;
  assign sub_wr = ACC_WR && ACC_SIZE == 2'h0 && ACC_ADDR == SCR_SYSTEM_CLOCK_MODE_ADDR && ACC_BIT == 2'h2;

  property p_carry_src;
    !$stable(CARRY) |-> $past(EXE_CARRY_WE) || $past(carry_wr);
  endproperty
  a_carry_src: assert property (p_carry_src) else $error("carry moved without a cause");
  // Reset itself is the subject here, so no disable
  property p_carry_keep;
    disable iff (1'b0) (!RSTN && PWR_DOWN) |=> CARRY == $past(CARRY);
  endproperty
  a_carry_keep: assert property (p_carry_keep) else $error("carry lost in power-down reset");
  property p_skip_src;
    !$stable(SKIP_CONDITION_FLAGS) |-> $past(EXE_SKIP_WE);
  endproperty
  a_skip_src: assert property (p_skip_src) else $error("skip flags moved without execution");
  property p_skip_load;
    EXE_SKIP_WE |=> SKIP_CONDITION_FLAGS == $past(EXE_SKIP);
  endproperty
  a_skip_load: assert property (p_skip_load) else $error("skip flags not loaded");
  property p_irq_gate;
    IRQ_SERVICE == (INTERRUPT_SERVICE_LEVEL == SCR_IS_ALL ? IRQ_PEND :
      INTERRUPT_SERVICE_LEVEL == SCR_IS_HIGH ? IRQ_PEND & INTERRUPT_PRIORITY_REGISTER : '0);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");
  property p_dm_window;
    DM_ALLOWED == (DM_ADDR >= SCR_DM_B15_LO || (MEMORY_BANK_ENABLE ? (DM_ADDR[11:8] <= SCR_DM_TOP_BANK ||
      DM_ADDR[11:8] == SCR_DM_SFR_BANK) : DM_ADDR <= SCR_DM_B0_HI));
  endproperty
  a_dm_window: assert property (p_dm_window) else $error("data memory window wrong");
  property p_work_bank;
    !WORKING_BANK_ENABLE |-> WORKING_BANK == 2'h0;
  endproperty
  a_work_bank: assert property (p_work_bank) else $error("working bank not zero");
  property p_pullup_low;
    ACC_WR && ACC_SIZE == 2'h2 && ACC_ADDR == SCR_PU_LOW_ADDR |=> PULLUP_EN[7:0] == $past(ACC_WDATA);
  endproperty
  a_pullup_low: assert property (p_pullup_low) else $error("pull-up byte not taken");
  property p_main_osc;
    ACC_WR && ACC_SIZE == 2'h0 && ACC_ADDR == SCR_SYSTEM_CLOCK_MODE_ADDR && ACC_BIT == 2'h3 |=>
      MAIN_OSC_EN != $past(ACC_WDATA[0]);
  endproperty
  a_main_osc: assert property (p_main_osc) else $error("main oscillator enable wrong");
  property p_sub_osc;
    !$stable(SUB_OSC_EN) |-> $past(sub_wr);
  endproperty
  a_sub_osc: assert property (p_sub_osc) else $error("sub oscillator moved alone");
  property p_serial_shift_buffer_gate;
    SIO_CLK_SEL[2:1] == 2'h0 |-> SERIAL_SHIFT_BUFFER_ACCESS_EN == (SIO_HALTED || SCK_PIN);
  endproperty
  a_serial_shift_buffer_gate: assert property (p_serial_shift_buffer_gate) else $error("buffer gate wrong");
  property p_serial_shift_buffer_cpu;
    SIO_CLK_SEL[2:1] == 2'h1 |-> SERIAL_SHIFT_BUFFER_ACCESS_EN;
  endproperty
  a_serial_shift_buffer_cpu: assert property (p_serial_shift_buffer_cpu) else $error("buffer locked on CPU clock");

  c_high_only: cover property (INTERRUPT_SERVICE_LEVEL == SCR_IS_HIGH && IRQ_SERVICE != '0);
  c_keep: cover property (disable iff (1'b0) !RSTN && PWR_DOWN && CARRY);
  c_fast: cover property (SIO_CLK_SEL == SCR_SIO_DIV4);
endmodule // scr_regs_sva

bind scr_regs scr_regs_sva #(.IRQ_N(IRQ_N)) i_scr_regs_sva (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .ACC_ADDR(ACC_ADDR), .ACC_SIZE(ACC_SIZE), .ACC_BIT(ACC_BIT),
  .ACC_WR(ACC_WR), .ACC_WDATA(ACC_WDATA), .EXE_CARRY_WE(EXE_CARRY_WE), .EXE_SKIP_WE(EXE_SKIP_WE),
  .EXE_SKIP(EXE_SKIP), .PWR_DOWN(PWR_DOWN), .CARRY(CARRY), .SKIP_CONDITION_FLAGS(SKIP_CONDITION_FLAGS),
  .INTERRUPT_SERVICE_LEVEL(INTERRUPT_SERVICE_LEVEL), .MEMORY_BANK_ENABLE(MEMORY_BANK_ENABLE),
  .WORKING_BANK_ENABLE(WORKING_BANK_ENABLE), .WORKING_BANK(WORKING_BANK), .IRQ_PEND(IRQ_PEND),
  .INTERRUPT_PRIORITY_REGISTER(INTERRUPT_PRIORITY_REGISTER), .IRQ_SERVICE(IRQ_SERVICE),
  .DM_ADDR(DM_ADDR), .DM_ALLOWED(DM_ALLOWED), .PULLUP_EN(PULLUP_EN), .MAIN_OSC_EN(MAIN_OSC_EN),
  .SUB_OSC_EN(SUB_OSC_EN), .SIO_HALTED(SIO_HALTED), .SCK_PIN(SCK_PIN), .SIO_CLK_SEL(SIO_CLK_SEL),
  .SERIAL_SHIFT_BUFFER_ACCESS_EN(SERIAL_SHIFT_BUFFER_ACCESS_EN));

// file: sim/scr_regs_tb.sv
// Self-checking bench for the system control register bank.
// Assumes scr_regs with its checker bound; the bench drives every port itself.
`timescale 1ns/1ns
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: %s", $time, m); end end
module scr_regs_tb
  import scr_pkg::*;
;
  logic clk_sys, rstn, acc_wr, acc_rd, acc_rvalid, exe_carry_we, exe_carry, exe_skip_we, exe_srb_we;
  logic pwr_down, carry, memory_bank_enable, working_bank_enable, dm_ok, main_en, sub_en, sub_sel, sio_halted, sck_pin, t0_clk;
  logic cpu_tick, shift_tick, ext_clk, serial_shift_buffer_en;
  logic [11:0] acc_addr, dm_addr;
  logic [1:0] acc_size, acc_bit, exe_srb, isl, wbank;
  logic [7:0] acc_wdata, acc_rdata, irq_pend, interrupt_priority_register, irq_service;
  logic [2:0] exe_skip, skip, sio_sel;
  logic [9:0] pullup_en;
  logic [7:0] exp_irq [4] = '{8'hf0, 8'h30, 8'h00, 8'h00};
  logic [11:0] dm_tab [6] = '{12'h07f, 12'h080, 12'h4ff, 12'h500, 12'hf7f, 12'hf80};
  logic [11:0] dm_exp = 12'hde1;
  int mismatches, check_count, n;

  scr_regs i_scr_regs (
    .CLK_SYS(clk_sys), .RSTN(rstn), .ACC_ADDR(acc_addr), .ACC_SIZE(acc_size), .ACC_BIT(acc_bit),
    .ACC_WR(acc_wr), .ACC_RD(acc_rd), .ACC_WDATA(acc_wdata), .ACC_RDATA(acc_rdata), .ACC_RVALID(acc_rvalid),
    .EXE_CARRY_WE(exe_carry_we), .EXE_CARRY(exe_carry), .EXE_SKIP_WE(exe_skip_we), .EXE_SKIP(exe_skip),
    .EXE_SRB_WE(exe_srb_we), .EXE_SRB(exe_srb), .PWR_DOWN(pwr_down), .CARRY(carry),
    .SKIP_CONDITION_FLAGS(skip), .INTERRUPT_SERVICE_LEVEL(isl), .MEMORY_BANK_ENABLE(memory_bank_enable),
    .WORKING_BANK_ENABLE(working_bank_enable), .WORKING_BANK(wbank), .IRQ_PEND(irq_pend), .INTERRUPT_PRIORITY_REGISTER(interrupt_priority_register),
    .IRQ_SERVICE(irq_service), .DM_ADDR(dm_addr), .DM_ALLOWED(dm_ok), .PULLUP_EN(pullup_en),
    .MAIN_OSC_EN(main_en), .SUB_OSC_EN(sub_en), .SUB_CLK_SEL(sub_sel), .SIO_HALTED(sio_halted),
    .SCK_PIN(sck_pin), .TIMER0_OUTPUT_CLOCK(t0_clk), .CPU_CLK_TICK(cpu_tick), .SIO_CLK_SEL(sio_sel),
    .SIO_SHIFT_TICK(shift_tick), .SIO_EXT_CLK(ext_clk), .SERIAL_SHIFT_BUFFER_ACCESS_EN(serial_shift_buffer_en));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ********************
  // Access tasks
  // ********************
  task automatic wr(input logic [11:0] a, input logic [1:0] s, input logic [1:0] b, input logic [7:0] d);
    @(posedge clk_sys);
    acc_addr <= a;
    acc_size <= s;
    acc_bit <= b;
    acc_wdata <= d;
    acc_wr <= 1'b1;
    @(posedge clk_sys);
    acc_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] s, input logic [7:0] e);
    @(posedge clk_sys);
    acc_addr <= a;
    acc_size <= s;
    acc_rd <= 1'b1;
    @(posedge clk_sys);
    acc_rd <= 1'b0;
    #1;
    `CHK({acc_rvalid, acc_rdata}, {1'b1, e}, "read answer")
  endtask

  task automatic exe(input logic c);
    @(posedge clk_sys);
    exe_carry_we <= 1'b1;
    exe_carry <= c;
    @(posedge clk_sys);
    exe_carry_we <= 1'b0;
    #1;
  endtask

  // Window must span whole prescaler periods so the count is phase free
  task automatic ticks(input logic [2:0] code, input int cyc, input int exp);
    int cnt;
    cnt = 0;
    wr(SCR_SERIAL_PORT_MODE_ADDR, 2'h2, 2'h0, {code, 5'h00});
    for (int i = 0; i < cyc; i++) begin
      @(posedge clk_sys);
      cpu_tick <= (i % 8 == 0);
      t0_clk <= (i % 8 == 4);
      #1;
      cnt += int'(shift_tick);
    end
    `CHK(cnt, exp, "shift tick count")
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    results();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    {acc_wr, acc_rd, exe_carry_we, exe_carry, exe_skip_we, exe_srb_we, pwr_down} = '0;
    {sio_halted, sck_pin, t0_clk, cpu_tick, acc_addr, acc_size, acc_bit, acc_wdata} = '0;
    {exe_skip, exe_srb, dm_addr} = '0;
    irq_pend = 8'hf0;
    interrupt_priority_register = 8'h3c;
    rstn = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    `CHK({main_en, sub_en, sub_sel, pullup_en, sio_sel}, 16'hc000, "reset outputs")
    rd(SCR_PSW_LO_ADDR, 2'h2, 8'h00);
    wr(SCR_PSW_LO_ADDR, 2'h2, 2'h0, 8'hf7);
    rd(SCR_PSW_LO_ADDR, 2'h2, 8'h07);
    `CHK(carry, 1'b0, "byte write reached carry")
    @(posedge clk_sys);
    exe_skip_we <= 1'b1;
    exe_skip <= 3'h5;
    exe_srb_we <= 1'b1;
    exe_srb <= 2'h3;
    @(posedge clk_sys);
    exe_skip_we <= 1'b0;
    exe_srb_we <= 1'b0;
    #1;
    `CHK(wbank, 2'h3, "operand bank")
    rd(SCR_PSW_LO_ADDR, 2'h2, 8'h57);
    rd(SCR_PSW_HI_ADDR, 2'h1, 8'h05);
    wr(SCR_PSW_HI_ADDR, 2'h0, 2'h3, 8'h01);
    `CHK(carry, 1'b1, "bit write of carry")
    wr(SCR_PSW_HI_ADDR, 2'h1, 2'h0, 8'h00);
    `CHK(carry, 1'b1, "nibble write reached carry")
    exe(1'b0);
    `CHK(carry, 1'b0, "carry from result")
    for (n = 0; n < 4; n++) begin
      wr(SCR_PSW_LO_ADDR, 2'h1, 2'h0, {4'h0, n[1:0], 2'h2});
      `CHK(irq_service, exp_irq[n], "service gating")
    end
    `CHK(wbank, 2'h0, "bank zero when disabled")
    for (n = 0; n < 12; n++) begin
      if (n % 6 == 0) begin
        wr(SCR_PSW_LO_ADDR, 2'h0, 2'h1, 8'(n / 6));
      end
      @(posedge clk_sys);
      dm_addr <= dm_tab[n % 6];
      #1;
      `CHK(dm_ok, dm_exp[n], "data memory window")
    end
    wr(SCR_PU_LOW_ADDR, 2'h2, 2'h0, 8'ha5);
    wr(SCR_PU_LOW_ADDR, 2'h1, 2'h0, 8'h0f);
    wr(SCR_PU_HIGH_ADDR, 2'h1, 2'h0, 8'h0e);
    `CHK(pullup_en, 10'h2a5, "pull-up bits")
    rd(SCR_PU_HIGH_ADDR, 2'h1, 8'h00);
    for (n = 0; n < 4; n++) begin
      wr(SCR_SYSTEM_CLOCK_MODE_ADDR, 2'h0, n[1:0], 8'h01);
    end
    wr(SCR_SYSTEM_CLOCK_MODE_ADDR, 2'h1, 2'h0, 8'h00);
    `CHK({main_en, sub_en, sub_sel}, 3'h1, "clock mode bits")
    rd(SCR_SYSTEM_CLOCK_MODE_ADDR, 2'h1, 8'h00);
    wr(SCR_SYSTEM_CLOCK_MODE_ADDR, 2'h0, 2'h2, 8'h00);
    exe(1'b1);
    @(posedge clk_sys);
    pwr_down <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(sub_en, 1'b1, "power-down stopped sub clock")
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    pwr_down <= 1'b0;
    #1;
    `CHK(carry, 1'b1, "carry lost in power-down reset")
    rd(SCR_PSW_LO_ADDR, 2'h2, 8'h00);
    for (n = 0; n < 8; n++) begin
      wr(SCR_SERIAL_PORT_MODE_ADDR, 2'h2, 2'h0, {n[2:0], 5'h1f});
      `CHK(sio_sel, n[2:0], "serial clock code")
      `CHK(ext_clk, n == 0, "external clock select")
      if (n < 4) `CHK(serial_shift_buffer_en, n > 1, "buffer access")
    end
    wr(SCR_SERIAL_PORT_MODE_ADDR, 2'h2, 2'h0, 8'h00);
    @(posedge clk_sys);
    sio_halted <= 1'b1;
    #1;
    `CHK(serial_shift_buffer_en, 1'b1, "halted buffer access")
    @(posedge clk_sys);
    sio_halted <= 1'b0;
    sck_pin <= 1'b1;
    #1;
    `CHK(serial_shift_buffer_en, 1'b1, "clock-high buffer access")
    ticks(3'h1, 64, 8);
    ticks(3'h2, 64, 8);
    // Divide-16 setting, never the CPU tick every 8 clocks
    ticks(3'h7, 160, 10);
    ticks(3'h4, 2048, 2);
    results();
  end
endmodule // scr_regs_tb
